// >>> logic/fes_supervisor.v
// Per-axis following-error supervision, drive enable and hold override
`timescale 1ns/1ns
`include "fes_defs.vh"

// Behaviour
// RQ1: Error magnitude beyond limit sets the fault bit in the condition word.
// RQ2: Axis fault raises motion fault by default; motion fault opens drive relay.
// RQ3: Limit resets to 2000 edges, held in user units.
// RQ4: Filter select: fault same period, or after 2 consecutive exceeding periods.
// RQ5: Error above warning threshold sets condition bit 1, no fault.
// RQ6: Error is demand position minus measured position every servo period.
// RQ7: Capture faulting error when loop goes off; clear when loop comes on. Code captures at the first axis fault after a clear.
// RQ8: Hold select -1 disables (reset), 0 to 63 picks the line.
// RQ9: Selected hold line is asserted when low.
// RQ10: Held move ramps to hold speed using the ramp rates, not cancelled.
// RQ11: Released hold ramps move back to its programmed speed.
// RQ12: Hold speed in user units, resets to zero, pausing the axis.
// RQ13: Hold affects only speed-controlled moves; linked, cam, geared run on.
// RQ14: Comparisons once per servo period against absolute error.
module fes_supervisor #(
    parameter POS_W = `FES_POS_W,
    parameter SPEED_W = `FES_SPEED_W,
    parameter COND_W = `FES_COND_W,
    parameter HOLD_LINES = 64,
    parameter FILTER_COUNT = `FES_FILTER_COUNT,
    parameter SERVO_CYCLES = `FES_SERVO_CYCLES
) (
    input wire ref_clk,
    input wire rst,
    input wire [POS_W-1:0] demandPosition,
    input wire [POS_W-1:0] measuredPosition,
    input wire limitWrite,
    input wire [POS_W-1:0] limitWriteData,
    input wire warnWrite,
    input wire [POS_W-1:0] warnWriteData,
    input wire limitFilterSelect,
    input wire faultRaisesMotion,
    input wire faultClear,
    input wire servoOn,
    input wire relayRequest,
    input wire holdSelectWrite,
    input wire [`FES_SEL_W-1:0] holdSelectWriteData,
    input wire holdSpeedWrite,
    input wire [SPEED_W-1:0] holdSpeedWriteData,
    input wire [HOLD_LINES-1:0] inputLines,
    input wire moveActive,
    input wire moveSpeedControlled,
    input wire [SPEED_W-1:0] programmedSpeed,
    input wire [SPEED_W-1:0] rampUpRate,
    input wire [SPEED_W-1:0] rampDownRate,
    output reg servoTick,
    output reg [POS_W-1:0] followingError,
    output reg [COND_W-1:0] axisConditionWord,
    output reg motionFault,
    output reg driveEnableRelay,
    output reg [POS_W-1:0] faultErrorCapture,
    output reg [POS_W-1:0] followingErrorLimit,
    output reg [POS_W-1:0] followingErrorWarnThreshold,
    output reg [`FES_SEL_W-1:0] holdInputSelect,
    output reg [SPEED_W-1:0] holdSpeed,
    output reg holdActive,
    output reg [SPEED_W-1:0] commandSpeed
);

    // ****************************************
    // Declarations
    // ****************************************
    localparam CNT_W = 32;
    localparam FILT_W = 4;
    localparam [CNT_W-1:0] TICK_LAST = SERVO_CYCLES - 1;
    localparam integer FILTER_INT = FILTER_COUNT;
    localparam [FILT_W-1:0] FILTER_LAST = FILTER_INT[FILT_W-1:0];
    localparam IDX_W = `FES_SEL_W - 1;

    reg [CNT_W-1:0] tickCount;
    reg [FILT_W-1:0] exceedRun;
    reg servoOnPrev;
    reg axisFaultRaised;
    wire [POS_W-1:0] errorValue;
    wire [POS_W-1:0] errorMagnitude;
    wire exceedsLimit;
    wire exceedsWarn;
    wire faultQualified;
    wire faultEvent;
    wire motionEvent;
    wire captureEvent;
    wire servoOnRise;
    wire [IDX_W-1:0] holdLineIndex;
    wire holdLineLow;
    wire holdEnabled;
    wire holdApplies;
    wire [SPEED_W-1:0] rampTarget;
    wire [SPEED_W-1:0] rampedSpeed;
    reg [FILT_W-1:0] next_exceedRun;

    // ****************************************
    // Servo period divider
    // ****************************************
    // Every comparison waits for this pulse so results stay period-aligned
    always @(posedge ref_clk) begin
        if (rst) begin
            tickCount <= {CNT_W{1'b0}};
            servoTick <= 1'b0;
        end else if (tickCount == TICK_LAST) begin
            tickCount <= {CNT_W{1'b0}};
            servoTick <= 1'b1; // see RQ14
        end else begin
            tickCount <= tickCount + {{(CNT_W-1){1'b0}}, 1'b1};
            servoTick <= 1'b0;
        end
    end

    // ****************************************
    // Configuration holding registers
    // ****************************************
    always @(posedge ref_clk) begin
        if (rst) begin
            followingErrorLimit <= `FES_LIMIT_RESET; // see RQ3
            followingErrorWarnThreshold <= `FES_WARN_RESET;
            holdInputSelect <= `FES_HOLD_SEL_RESET; // see RQ8
            holdSpeed <= `FES_HOLD_SPEED_RESET; // see RQ12
        end else begin
            if (limitWrite) begin
                followingErrorLimit <= limitWriteData;
            end
            if (warnWrite) begin
                followingErrorWarnThreshold <= warnWriteData;
            end
            // Values outside -1 and 0 to 63 are ignored
            if (holdSelectWrite &&
                (holdSelectWriteData == `FES_HOLD_SEL_RESET ||
                 !holdSelectWriteData[`FES_SEL_W-1])) begin
                holdInputSelect <= holdSelectWriteData; // see RQ8
            end
            if (holdSpeedWrite) begin
                holdSpeed <= holdSpeedWriteData; // see RQ12
            end
        end
    end

    // ****************************************
    // Error computation and comparison
    // ****************************************
    fes_error_compare #(
        .POS_W(POS_W)
    ) u_compare (
        .demandPosition(demandPosition),
        .measuredPosition(measuredPosition),
        .followingErrorLimit(followingErrorLimit),
        .followingErrorWarnThreshold(followingErrorWarnThreshold),
        .errorValue(errorValue),
        .errorMagnitude(errorMagnitude),
        .exceedsLimit(exceedsLimit),
        .exceedsWarn(exceedsWarn)
    );

    always @(posedge ref_clk) begin
        if (rst) begin
            followingError <= {POS_W{1'b0}};
        end else if (servoTick) begin
            followingError <= errorValue; // see RQ6
        end
    end

    // ****************************************
    // Limit filter
    // ****************************************
    // Run of consecutive exceeding periods, saturating at the filter length
    always @* begin
        next_exceedRun = exceedRun;
        if (!exceedsLimit) begin
            next_exceedRun = {FILT_W{1'b0}};
        end else if (exceedRun < FILTER_LAST) begin
            next_exceedRun = exceedRun + {{(FILT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            exceedRun <= {FILT_W{1'b0}};
        end else if (servoTick) begin
            exceedRun <= next_exceedRun; // see RQ4
        end
    end

    // Filtered mode trades a period of latency for immunity to a lone spike
    assign faultQualified = limitFilterSelect ? (next_exceedRun >= FILTER_LAST)
        : exceedsLimit; // see RQ4
    assign faultEvent = servoTick && faultQualified; // see RQ1
    // Motion fault follows only while the axis fault is set to propagate
    assign motionEvent = faultEvent && faultRaisesMotion; // see RQ2

    // ****************************************
    // Condition word and faults
    // ****************************************
    always @(posedge ref_clk) begin
        if (rst) begin
            axisConditionWord <= `FES_COND_RESET;
        end else begin
            if (servoTick) begin
                axisConditionWord[`FES_COND_WARN_BIT] <= exceedsWarn; // see RQ5
            end
            // Set wins over a clear in the same cycle
            if (faultEvent) begin
                axisConditionWord[`FES_COND_FAULT_BIT] <= 1'b1; // see RQ1
            end else if (faultClear) begin
                axisConditionWord[`FES_COND_FAULT_BIT] <= 1'b0;
            end
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            axisFaultRaised <= 1'b0;
            motionFault <= 1'b0;
        end else begin
            if (faultEvent) begin
                axisFaultRaised <= 1'b1;
            end else if (faultClear) begin
                axisFaultRaised <= 1'b0;
            end
            if (motionEvent) begin
                motionFault <= 1'b1; // see RQ2
            end else if (faultClear) begin
                motionFault <= 1'b0;
            end
        end
    end

    // Relay opens on the same edge as the motion fault, never a cycle late
    always @(posedge ref_clk) begin
        if (rst) begin
            driveEnableRelay <= 1'b0;
        end else begin
            driveEnableRelay <= relayRequest && !motionFault && !motionEvent; // see RQ2
        end
    end

    // ****************************************
    // Faulting error capture
    // ****************************************
    // Only the first event after a clear is kept
    assign captureEvent = faultEvent && !motionFault && !axisFaultRaised;
    assign servoOnRise = servoOn && !servoOnPrev;

    // Loop is forced off by the motion fault; capture is at the first axis fault event after a clear
    always @(posedge ref_clk) begin
        if (rst) begin
            servoOnPrev <= 1'b0;
            faultErrorCapture <= {POS_W{1'b0}};
        end else begin
            servoOnPrev <= servoOn;
            if (captureEvent) begin
                faultErrorCapture <= errorValue; // see RQ7
            end else if (servoOnRise) begin
                faultErrorCapture <= {POS_W{1'b0}}; // see RQ7
            end
        end
    end

    // ****************************************
    // Hold input and speed override
    // ****************************************
    assign holdEnabled = !holdInputSelect[`FES_SEL_W-1]; // see RQ8
    // While disabled the index lands on the top line; the enable masks it
    assign holdLineIndex = holdInputSelect[IDX_W-1:0];
    assign holdLineLow = !inputLines[holdLineIndex]; // see RQ9
    assign holdApplies = holdActive && moveSpeedControlled; // see RQ13
    // Release returns the same move to its own programmed speed
    assign rampTarget = !moveActive ? {SPEED_W{1'b0}}
        : (holdApplies ? holdSpeed : programmedSpeed); // see RQ10 RQ11

    always @(posedge ref_clk) begin
        if (rst) begin
            holdActive <= 1'b0;
        end else begin
            holdActive <= holdEnabled && holdLineLow; // see RQ9
        end
    end

    fes_speed_ramp #(
        .SPEED_W(SPEED_W)
    ) u_ramp (
        .ref_clk(ref_clk),
        .rst(rst),
        .stepEnable(servoTick),
        .targetSpeed(rampTarget),
        .rampUpRate(rampUpRate),
        .rampDownRate(rampDownRate),
        .rampedSpeed(rampedSpeed)
    );

    // Linked, cam and geared moves bypass the ramp entirely
    always @(posedge ref_clk) begin
        if (rst) begin
            commandSpeed <= {SPEED_W{1'b0}};
        end else if (moveSpeedControlled) begin
            commandSpeed <= rampedSpeed; // see RQ10 RQ11
        end else begin
            commandSpeed <= programmedSpeed; // see RQ13
        end
    end

endmodule

// >>> logic/fes_defs.vh
// Constants for the following-error supervisor and hold logic
`ifndef FES_DEFS_VH
`define FES_DEFS_VH

// ****************************************
// Widths
// ****************************************
`define FES_POS_W 32
`define FES_SPEED_W 32
`define FES_COND_W 16
`define FES_SEL_W 7

// ****************************************
// Reset values
// ****************************************
`define FES_LIMIT_RESET 32'h000007D0
`define FES_WARN_RESET 32'h7FFFFFFF
`define FES_HOLD_SEL_RESET 7'h7F
`define FES_HOLD_SPEED_RESET 32'h00000000
`define FES_COND_RESET 16'h0000

// ****************************************
// Condition word fields
// ****************************************
`define FES_COND_WARN_BIT 1
`define FES_COND_FAULT_BIT 8

// ****************************************
// Filter and timing
// ****************************************
`define FES_FILTER_COUNT 2
`define FES_CLK_HZ 10000000
`define FES_SERVO_PERIOD_US 1000
`define FES_SERVO_CYCLES ((`FES_CLK_HZ / 1000000) * `FES_SERVO_PERIOD_US)

`endif

// >>> logic/fes_error_compare.v
// Following-error magnitude and threshold comparison
`timescale 1ns/1ns
`include "fes_defs.vh"

module fes_error_compare #(
    parameter POS_W = `FES_POS_W
) (
    input wire [POS_W-1:0] demandPosition,
    input wire [POS_W-1:0] measuredPosition,
    input wire [POS_W-1:0] followingErrorLimit,
    input wire [POS_W-1:0] followingErrorWarnThreshold,
    output wire [POS_W-1:0] errorValue,
    output wire [POS_W-1:0] errorMagnitude,
    output wire exceedsLimit,
    output wire exceedsWarn
);
    // Wraps like the position counters themselves
    assign errorValue = demandPosition - measuredPosition; // see RQ6
    // Most negative value saturates rather than wrapping to itself
    assign errorMagnitude = errorValue[POS_W-1] ?
        ((errorValue == {1'b1, {(POS_W-1){1'b0}}}) ? {1'b0, {(POS_W-1){1'b1}}}
        : (~errorValue + {{(POS_W-1){1'b0}}, 1'b1})) : errorValue; // see RQ14
    assign exceedsLimit = errorMagnitude > followingErrorLimit; // see RQ1
    assign exceedsWarn = errorMagnitude > followingErrorWarnThreshold; // see RQ5
endmodule

// >>> logic/fes_speed_ramp.v
// Speed ramp toward a target at separate up and down rates
`timescale 1ns/1ns
`include "fes_defs.vh"

module fes_speed_ramp #(
    parameter SPEED_W = `FES_SPEED_W
) (
    input wire ref_clk,
    input wire rst,
    input wire stepEnable,
    input wire [SPEED_W-1:0] targetSpeed,
    input wire [SPEED_W-1:0] rampUpRate,
    input wire [SPEED_W-1:0] rampDownRate,
    output reg [SPEED_W-1:0] rampedSpeed
);
    reg [SPEED_W-1:0] next_rampedSpeed;

    always @* begin
        next_rampedSpeed = rampedSpeed;
        if (rampedSpeed < targetSpeed) begin
            // Clip so the step never overshoots the target
            if (targetSpeed - rampedSpeed > rampUpRate) begin
                next_rampedSpeed = rampedSpeed + rampUpRate;
            end else begin
                next_rampedSpeed = targetSpeed;
            end
        end else if (rampedSpeed > targetSpeed) begin
            if (rampedSpeed - targetSpeed > rampDownRate) begin
                next_rampedSpeed = rampedSpeed - rampDownRate;
            end else begin
                next_rampedSpeed = targetSpeed;
            end
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            rampedSpeed <= {SPEED_W{1'b0}};
        end else if (stepEnable) begin
            rampedSpeed <= next_rampedSpeed; // see RQ10
        end
    end
endmodule

// >>> test/fes_supervisor_sva.sv
// Assertion checker for the following-error supervisor
`timescale 1ns/1ns
module fes_supervisor_sva (
    input wire ref_clk,
    input wire rst,
    input wire [31:0] demandPosition,
    input wire [31:0] measuredPosition,
    input wire limitWrite,
    input wire [31:0] limitWriteData,
    input wire limitFilterSelect,
    input wire faultRaisesMotion,
    input wire servoOn,
    input wire moveSpeedControlled,
    input wire [31:0] programmedSpeed,
    input wire [63:0] inputLines,
    input wire servoTick,
    input wire [31:0] followingError,
    input wire [15:0] axisConditionWord,
    input wire motionFault,
    input wire driveEnableRelay,
    input wire [31:0] faultErrorCapture,
    input wire [31:0] followingErrorLimit,
    input wire [31:0] followingErrorWarnThreshold,
    input wire [6:0] holdInputSelect,
    input wire holdActive,
    input wire [31:0] commandSpeed
);
    // ********
    // Helpers
    // ********
    wire [31:0] err = demandPosition - measuredPosition;
    wire [31:0] mag = err[31] ? -err : err;
    wire overLim = mag > followingErrorLimit;
    wire overWarn = mag > followingErrorWarnThreshold;
    // Index wraps to line 63 when disabled, masked by the select test
    wire holdNow = (holdInputSelect < 7'h40) && !inputLines[holdInputSelect[5:0]];
    reg prevOver;
    reg holdPrev;
    always @(posedge ref_clk) begin
        if (rst) begin
            prevOver <= 1'b0;
            holdPrev <= 1'b0;
        end else begin
            holdPrev <= holdNow;
            if (servoTick) begin
                prevOver <= overLim;
            end
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_fault_now: assert property (servoTick && !limitFilterSelect && overLim |=> axisConditionWord[8])
        else $error("fault bit missing after excess");
    a_filter_single: assert property (servoTick && limitFilterSelect && overLim && !prevOver
        && !axisConditionWord[8] |=> !axisConditionWord[8])
        else $error("single excursion raised fault");
    a_filter_second: assert property (servoTick && limitFilterSelect && overLim && prevOver
        |=> axisConditionWord[8])
        else $error("second excursion missed");
    a_motion_follows: assert property ($rose(axisConditionWord[8]) && faultRaisesMotion |-> motionFault)
        else $error("motion fault not raised");
    a_relay_open: assert property (motionFault |-> !driveEnableRelay)
        else $error("relay closed during motion fault");
    a_warn_bit: assert property (servoTick |=> axisConditionWord[1] == $past(overWarn))
        else $error("warn bit wrong");
    a_capture_value: assert property ($rose(motionFault) |-> faultErrorCapture == followingError)
        else $error("capture differs from error");
    a_capture_clear: assert property ($rose(servoOn) |-> ##[1:2] faultErrorCapture == 32'h0)
        else $error("capture not cleared");
    a_hold_level: assert property (holdActive == holdPrev)
        else $error("hold state wrong");
    a_not_speed: assert property (!moveSpeedControlled |=> commandSpeed == $past(programmedSpeed))
        else $error("non speed move altered");
    a_servo_period: assert property (servoTick |=> !servoTick [*7] ##1 servoTick)
        else $error("servo period wrong");
    a_limit_load: assert property (limitWrite |=> followingErrorLimit == $past(limitWriteData))
        else $error("limit not loaded");
endmodule
bind fes_supervisor fes_supervisor_sva u_sva (.ref_clk, .rst, .demandPosition, .measuredPosition,
    .limitWrite, .limitWriteData, .limitFilterSelect, .faultRaisesMotion, .servoOn,
    .moveSpeedControlled, .programmedSpeed, .inputLines, .servoTick, .followingError,
    .axisConditionWord, .motionFault, .driveEnableRelay, .faultErrorCapture,
    .followingErrorLimit, .followingErrorWarnThreshold, .holdInputSelect, .holdActive,
    .commandSpeed);

// >>> test/fes_drive_model.sv
// Model of the drive, encoder feedback and discrete input lines
`timescale 1ns/1ns
module fes_drive_model (
    input wire [31:0] demandPosition,
    input wire [31:0] errOffset,
    input wire [5:0] holdLine,
    input wire holdLow,
    output wire [31:0] measuredPosition,
    output wire [63:0] inputLines
);
    // Encoder lags demand by whatever error the bench asks for
    assign measuredPosition = demandPosition - errOffset;
    // Unused lines rest at their pull-up level
    assign inputLines = ~({63'h0, holdLow} << holdLine);
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the following-error supervisor
`timescale 1ns/1ns
module tb_top;
    reg ref_clk = 1'b0;
    reg rst = 1'b1;
    reg [31:0] demandPosition = 32'h0, errOffset = 32'h0, warnT = 32'h7FFFFFFF;
    reg limitWrite = 1'b0, warnWrite = 1'b0, holdSelectWrite = 1'b0, holdSpeedWrite = 1'b0;
    reg [31:0] limitWriteData = 32'h0, warnWriteData = 32'h0, holdSpeedWriteData = 32'h0;
    reg [6:0] holdSelectWriteData = 7'h0;
    reg limitFilterSelect = 1'b0, faultRaisesMotion = 1'b1, faultClear = 1'b0;
    reg servoOn = 1'b1, relayRequest = 1'b1, moveActive = 1'b1, moveSpeedControlled = 1'b1;
    reg [31:0] programmedSpeed = 32'h64, rampUpRate = 32'h1E, rampDownRate = 32'h1E;
    reg holdLow = 1'b0, fsticky = 1'b0, msticky = 1'b0, tickD = 1'b0;
    reg [34:0] expQ[$];
    reg [34:0] e;
    integer n_fail = 0, n_checks = 0, cycles = 0, seed = 4, r;
    wire [31:0] measuredPosition, followingError, faultErrorCapture, followingErrorLimit;
    wire [31:0] followingErrorWarnThreshold, holdSpeed, commandSpeed;
    wire [63:0] inputLines;
    wire [15:0] axisConditionWord;
    wire [6:0] holdInputSelect;
    wire servoTick, motionFault, driveEnableRelay, holdActive;
    // ********
    // Harness
    // ********
    fes_supervisor #(.SERVO_CYCLES(8)) DUT (.ref_clk, .rst, .demandPosition, .measuredPosition,
        .limitWrite, .limitWriteData, .warnWrite, .warnWriteData, .limitFilterSelect,
        .faultRaisesMotion, .faultClear, .servoOn, .relayRequest, .holdSelectWrite,
        .holdSelectWriteData, .holdSpeedWrite, .holdSpeedWriteData, .inputLines, .moveActive,
        .moveSpeedControlled, .programmedSpeed, .rampUpRate, .rampDownRate, .servoTick,
        .followingError, .axisConditionWord, .motionFault, .driveEnableRelay, .faultErrorCapture,
        .followingErrorLimit, .followingErrorWarnThreshold, .holdInputSelect, .holdSpeed,
        .holdActive, .commandSpeed);
    fes_drive_model u_drive (.demandPosition, .errOffset, .holdLine(6'h03), .holdLow,
        .measuredPosition, .inputLines);
    always #50 ref_clk = ~ref_clk;
    task stop_test;
        begin
            $display("Checks %0d, errors %0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    task chk(input string name, input [31:0] x, input [31:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== x) begin
                n_fail = n_fail + 1;
                $display("Error %s expected %h seen %h", name, x, g);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask
    task waitTick;
        integer k;
        begin
            k = 0;
            @(posedge ref_clk);
            while (servoTick !== 1'b1 && k < 20) begin
                @(posedge ref_clk);
                k = k + 1;
            end
            #5;
        end
    endtask
    // One servo period with a chosen error; the note is checked by the monitor
    task tick(input [31:0] off, input f);
        begin
            errOffset = off;
            demandPosition = $random(seed);
            fsticky = fsticky | f;
            msticky = msticky | (f & faultRaisesMotion);
            expQ.push_back({((off[31] ? -off : off) > warnT), fsticky, msticky, off});
            waitTick;
        end
    endtask
    // s: 0 warn, 1 hold select, 2 hold speed, 3 limit
    task wr(input [1:0] s, input [31:0] d);
        begin
            limitWriteData = d;
            warnWriteData = d;
            holdSelectWriteData = d[6:0];
            holdSpeedWriteData = d;
            limitWrite = (s == 2'h3);
            warnWrite = (s == 2'h0);
            holdSelectWrite = (s == 2'h1);
            holdSpeedWrite = (s == 2'h2);
            cyc(1);
            {limitWrite, warnWrite, holdSelectWrite, holdSpeedWrite} = 4'h0;
            cyc(1);
        end
    endtask
    task clr;
        begin
            faultClear = 1'b1;
            cyc(1);
            faultClear = 1'b0;
            fsticky = 1'b0;
            msticky = 1'b0;
            cyc(1);
        end
    endtask
    always @(posedge ref_clk) begin
        if (tickD && expQ.size() > 0) begin
            e = expQ.pop_front();
            chk("followingError", e[31:0], followingError);
            chk("warnBit", e[34], axisConditionWord[1]);
            chk("faultBit", e[33], axisConditionWord[8]);
            chk("motionFault", e[32], motionFault);
        end
        tickD <= servoTick;
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            stop_test;
        end
    end
    initial begin
        cyc(20);
        rst = 1'b0;
        chk("limit", 32'h7D0, followingErrorLimit);
        chk("holdSel", 32'h7F, holdInputSelect);
        chk("holdSpeed", 32'h0, holdSpeed);
        chk("warnThr", 32'h7FFFFFFF, followingErrorWarnThreshold);
        wr(2'h0, 32'h3E8);
        chk("warnThr", 32'h3E8, followingErrorWarnThreshold);
        warnT = 32'h3E8;
        tick(32'h5, 1'b0);
        tick(32'hFFFFFB50, 1'b0);
        tick(32'h7D0, 1'b0);
        tick(32'h7D1, 1'b1);
        chk("capture", 32'h7D1, faultErrorCapture);
        chk("relay", 32'h0, driveEnableRelay);
        tick(32'h5, 1'b0);
        chk("capture", 32'h7D1, faultErrorCapture);
        servoOn = 1'b0;
        cyc(2);
        servoOn = 1'b1;
        cyc(3);
        chk("capture", 32'h0, faultErrorCapture);
        clr;
        limitFilterSelect = 1'b1;
        wr(2'h3, 32'hBB7);
        tick(32'h0, 1'b0);
        tick(32'hFFFFF448, 1'b0);
        tick(32'h0, 1'b0);
        tick(32'hFFFFF448, 1'b0);
        tick(32'hFFFFF448, 1'b1);
        clr;
        limitFilterSelect = 1'b0;
        repeat (6) begin
            r = $random(seed) % 1500;
            tick(r, 1'b0);
        end
        // Axis fault without motion fault keeps the relay closed
        faultRaisesMotion = 1'b0;
        tick(32'hFFFFF000, 1'b1);
        chk("relay", 32'h1, driveEnableRelay);
        errOffset = 32'h0;
        clr;
        faultRaisesMotion = 1'b1;
        wr(2'h2, 32'hA);
        chk("holdSpeed", 32'hA, holdSpeed);
        wr(2'h1, 32'h40);
        chk("holdSel", 32'h7F, holdInputSelect);
        wr(2'h1, 32'h3);
        chk("holdSel", 32'h3, holdInputSelect);
        repeat (5) waitTick;
        chk("holdActive", 32'h0, holdActive);
        chk("speed", 32'h64, commandSpeed);
        holdLow = 1'b1;
        cyc(2);
        chk("holdActive", 32'h1, holdActive);
        waitTick;
        cyc(1);
        chk("speed", 32'h46, commandSpeed);
        repeat (4) waitTick;
        chk("speed", 32'hA, commandSpeed);
        holdLow = 1'b0;
        waitTick;
        cyc(1);
        chk("speed", 32'h28, commandSpeed);
        repeat (4) waitTick;
        chk("speed", 32'h64, commandSpeed);
        holdLow = 1'b1;
        moveSpeedControlled = 1'b0;
        programmedSpeed = 32'h37;
        cyc(2);
        chk("speed", 32'h37, commandSpeed);
        stop_test;
    end
endmodule
